//--- shared/routing_pkg.sv
`default_nettype none
package routing_pkg;

	// --------------------------------------------------------------
	// Field and word layout
	// --------------------------------------------------------------
	localparam int              FIELD_W         = 6;
	localparam int              FIELDS_PER_WORD = 5;
	localparam int              WORD_W          = FIELD_W * FIELDS_PER_WORD;
	localparam logic [5:0]      CODE_HIGH       = 6'h3F;
	localparam logic [5:0]      CODE_LOW        = 6'h3E;
	localparam logic [5:0]      FIELD_RESET     = CODE_LOW;
	localparam logic [29:0]     WORD_RESET      = {FIELDS_PER_WORD{FIELD_RESET}};

	// --------------------------------------------------------------
	// Audio side sizes
	// --------------------------------------------------------------
	localparam int AUDIO_PINS      = 20;
	localparam int AUDIO_CLK_N     = 8;
	localparam int AUDIO_DATA_N    = 8;
	localparam int AUDIO_FS_N      = 8;
	localparam int AUDIO_IRQ_N     = 10;
	localparam int AUDIO_MISC_N    = 6;
	localparam int AUDIO_CLK_SRC   = 9;
	localparam int AUDIO_DATA_SRC  = 16;
	localparam int AUDIO_FS_SRC    = 16;
	localparam int AUDIO_PIN_SRC   = 24;
	localparam int AUDIO_MISC_SRC  = 8;
	localparam int AUDIO_EN_SRC    = 16;

	// --------------------------------------------------------------
	// Peripheral side sizes
	// --------------------------------------------------------------
	localparam int PERIPH_PINS     = 14;
	localparam int PERIPH_IN_N     = 8;
	localparam int PERIPH_IRQ_N    = 9;
	localparam int PERIPH_MISC_N   = 9;
	localparam int PERIPH_MISC_SRC = 16;
	localparam int PERIPH_PIN_SRC  = 24;
	localparam int PERIPH_EN_SRC   = 24;

	// --------------------------------------------------------------
	// Field base indices, one run per routed signal set
	// --------------------------------------------------------------
	localparam int F_CLK    = 0;
	localparam int F_DATA   = F_CLK + AUDIO_CLK_N;
	localparam int F_FS     = F_DATA + AUDIO_DATA_N;
	localparam int F_APIN   = F_FS + AUDIO_FS_N;
	localparam int F_AIRQ   = F_APIN + AUDIO_PINS;
	localparam int F_AMISC  = F_AIRQ + AUDIO_IRQ_N;
	localparam int F_AEN    = F_AMISC + AUDIO_MISC_N;
	localparam int F_PIN_IN = F_AEN + AUDIO_PINS;
	localparam int F_PIRQ   = F_PIN_IN + PERIPH_IN_N;
	localparam int F_PMISC  = F_PIRQ + PERIPH_IRQ_N;
	localparam int F_PPIN   = F_PMISC + PERIPH_MISC_N;
	localparam int F_PEN    = F_PPIN + PERIPH_PINS;
	localparam int FIELDS   = F_PEN + PERIPH_PINS;
	localparam int WORDS    = (FIELDS + FIELDS_PER_WORD - 1) / FIELDS_PER_WORD;

	// --------------------------------------------------------------
	// Register map (byte addresses)
	// --------------------------------------------------------------
	localparam int          ADDR_W          = 12;
	localparam logic [11:0] CFG_BASE_OFS    = 12'h000;
	localparam logic [11:0] INVERT_OFS      = 12'h080;
	localparam logic [11:0] AUDIO_STAT_OFS  = 12'h084;
	localparam logic [11:0] PERIPH_STAT_OFS = 12'h088;

	localparam int INV_PIN19 = 0;
	localparam int INV_PIN20 = 1;
	localparam int INV_MISC4 = 2;
	localparam int INV_MISC5 = 3;
	localparam int INV_W     = 4;
	localparam logic [3:0] INVERT_RESET = 4'h0;

	// Zero-based indices of the invertible buffers
	localparam int PIN19_IDX = 18;
	localparam int PIN20_IDX = 19;
	localparam int MISC4_IDX = 4;
	localparam int MISC5_IDX = 5;

endpackage : routing_pkg
`default_nettype wire

//--- rtl/signal_routing_matrix.sv
// Behaviour
// R01: Each group has its own source codes and its own configuration fields.
// R02: Each field belongs to one routed input; its code picks the source.
// R03: One source code may appear in any number of fields of a group.
// R04: Every routed input is driven by exactly one output source.
// R05: Fields only pick sources of their own group; misc and pin paths cross.
// R06: Audio unit has clock, data, frame sync, pin, misc and enable groups.
// R07: Peripheral unit has misc, pin output and pin enable groups.
// R08: Every group may pick pin levels; only pin group drives pin values.
// R09: Pin driven from its routed value when enable is 1, else input.
// R10: Audio unit has twenty pin buffers with value and enable fields.
// R11: Peripheral unit has fourteen pin buffers with value and enable fields.
// R12: Constant high and low codes are selectable in every group.
// R13: Audio pins 19 and 20 may invert received level unless self routed.
// R14: Audio misc buffers 4 and 5 may invert their routed level.
// R15: Audio misc buffers feed no peripheral; they reappear in enable group.
// R16: Audio misc group has ten interrupt routes and six misc buffers.
// R17: Peripheral misc group has nine interrupt routes and nine misc buffers.
// R18: Pin enables may come from pin levels and other non-owner signals.
// R19: Audio clocks pick port clocks, generator clocks, rx clock, pins, consts.
// R20: After reset every routed input is tied low.
// R21: Software reads current audio and peripheral pin levels.
// R22: Route changes reach outputs within one clock, no other route disturbed.
// R23: Undefined codes route logic low.
`timescale 1ns/1ps
`default_nettype none

module signal_routing_matrix
	import routing_pkg::*;
#(
	parameter int CLK_SRC_W  = routing_pkg::AUDIO_CLK_SRC,
	parameter int DATA_SRC_W = routing_pkg::AUDIO_DATA_SRC,
	parameter int FS_SRC_W   = routing_pkg::AUDIO_FS_SRC
) (
	input  wire logic                                     clk,
	input  wire logic                                     resetn,
	input  wire logic                                     psel,
	input  wire logic                                     penable,
	input  wire logic                                     pwrite,
	input  wire logic [routing_pkg::ADDR_W-1:0]           paddr,
	input  wire logic [31:0]                              pwdata,
	input  wire logic [3:0]                               pstrb,
	output logic                                          pready,
	output logic [31:0]                                   prdata,
	output logic                                          pslverr,
	input  wire logic [CLK_SRC_W-1:0]                     audioClkSrc,
	output logic [routing_pkg::AUDIO_CLK_N-1:0]           audioClkIn,
	input  wire logic [DATA_SRC_W-1:0]                    audioDataSrc,
	output logic [routing_pkg::AUDIO_DATA_N-1:0]          audioDataIn,
	input  wire logic [FS_SRC_W-1:0]                      audioFsSrc,
	output logic [routing_pkg::AUDIO_FS_N-1:0]            audioFsIn,
	input  wire logic [routing_pkg::AUDIO_PIN_SRC-1:0]    audioPinSrc,
	input  wire logic [routing_pkg::AUDIO_MISC_SRC-1:0]   audioMiscSrc,
	output logic [routing_pkg::AUDIO_IRQ_N-1:0]           audioIrqRouteIn,
	input  wire logic [routing_pkg::AUDIO_EN_SRC-1:0]     audioEnSrc,
	input  wire logic [routing_pkg::AUDIO_PINS-1:0]       audioPinIn,
	output logic [routing_pkg::AUDIO_PINS-1:0]            audioPinOut,
	output logic [routing_pkg::AUDIO_PINS-1:0]            audioPinOe,
	input  wire logic [routing_pkg::PERIPH_MISC_SRC-1:0]  periphMiscSrc,
	output logic [routing_pkg::PERIPH_IN_N-1:0]           periphMiscIn,
	output logic [routing_pkg::PERIPH_IRQ_N-1:0]          periphIrqRouteIn,
	input  wire logic [routing_pkg::PERIPH_PIN_SRC-1:0]   periphPinSrc,
	input  wire logic [routing_pkg::PERIPH_EN_SRC-1:0]    periphEnSrc,
	input  wire logic [routing_pkg::PERIPH_PINS-1:0]      periphPinIn,
	output logic [routing_pkg::PERIPH_PINS-1:0]           periphPinOut,
	output logic [routing_pkg::PERIPH_PINS-1:0]           periphPinOe
);
	import routing_pkg::*;

	// ------------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------------
	// Codes past a group's last source, except CODE_HIGH, hit zero padding, so they read low
	function automatic logic pick(input logic [63:0] vec,
		input logic [5:0] code);
		pick = (code == CODE_HIGH) | vec[code]; // R12 R23
	endfunction : pick

	// ------------------------------------------------------------------
	// Configuration storage
	// ------------------------------------------------------------------
	logic [WORD_W-1:0]   cfgWord [WORDS];
	logic [INV_W-1:0]    invert;
	wire  [5:0]          field [WORDS*FIELDS_PER_WORD];

	genvar gw, gf;
	generate
		for (gw = 0; gw < WORDS; gw++) begin : g_word
			for (gf = 0; gf < FIELDS_PER_WORD; gf++) begin : g_fld
				// R02
				assign field[gw*FIELDS_PER_WORD+gf] =
					cfgWord[gw][gf*FIELD_W +: FIELD_W];
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Received pin levels
	// ------------------------------------------------------------------
	wire  selfRoute19 = field[F_APIN+PIN19_IDX] == 6'(PIN19_IDX);
	wire  selfRoute20 = field[F_APIN+PIN20_IDX] == 6'(PIN20_IDX);
	logic [AUDIO_PINS-1:0] audioLevel;

	always_comb begin
		audioLevel = audioPinIn;
		// Self-routed buffers keep true polarity to avoid a loop
		audioLevel[PIN19_IDX] = audioPinIn[PIN19_IDX] ^
			(invert[INV_PIN19] & ~selfRoute19); // R13
		audioLevel[PIN20_IDX] = audioPinIn[PIN20_IDX] ^
			(invert[INV_PIN20] & ~selfRoute20); // R13
	end

	// ------------------------------------------------------------------
	// Per-group source vectors: pins first, then group's own outputs
	// ------------------------------------------------------------------
	wire [AUDIO_MISC_N-1:0]  audioMiscBuf;
	wire [PERIPH_MISC_N-1:0] periphMiscBuf;

	// R01 R05 R08 R19
	wire [63:0] vecClk  = 64'({audioClkSrc, audioLevel});
	wire [63:0] vecData = 64'({audioDataSrc, audioLevel});
	wire [63:0] vecFs   = 64'({audioFsSrc, audioLevel});
	wire [63:0] vecAPin = 64'({audioPinSrc, audioLevel});
	wire [63:0] vecAMsc = 64'({audioMiscSrc, audioLevel});
	// Misc buffer outputs cross into the enable group here
	wire [63:0] vecAEn  = 64'({audioMiscBuf, audioEnSrc, audioLevel}); // R15 R18
	wire [63:0] vecPMsc = 64'({periphMiscSrc, periphPinIn});
	wire [63:0] vecPPin = 64'({periphPinSrc, periphPinIn});
	wire [63:0] vecPEn  = 64'({periphMiscBuf, periphEnSrc, periphPinIn}); // R18

	// ------------------------------------------------------------------
	// Routed values, one mux per field
	// ------------------------------------------------------------------
	wire [AUDIO_CLK_N-1:0]   next_audioClkIn;
	wire [AUDIO_DATA_N-1:0]  next_audioDataIn;
	wire [AUDIO_FS_N-1:0]    next_audioFsIn;
	wire [AUDIO_PINS-1:0]    next_audioPinOut;
	wire [AUDIO_IRQ_N-1:0]   next_audioIrqRouteIn;
	wire [AUDIO_MISC_N-1:0]  audioMiscRaw;
	wire [AUDIO_PINS-1:0]    next_audioPinOe;
	wire [PERIPH_IN_N-1:0]   next_periphMiscIn;
	wire [PERIPH_IRQ_N-1:0]  next_periphIrqRouteIn;
	wire [PERIPH_PINS-1:0]   next_periphPinOut;
	wire [PERIPH_PINS-1:0]   next_periphPinOe;

	genvar i;
	generate
		// R06 R19
		for (i = 0; i < AUDIO_CLK_N; i++) begin : g_clk
			assign next_audioClkIn[i] = pick(vecClk, field[F_CLK+i]); // R03
		end
		for (i = 0; i < AUDIO_DATA_N; i++) begin : g_data
			assign next_audioDataIn[i] = pick(vecData, field[F_DATA+i]);
		end
		for (i = 0; i < AUDIO_FS_N; i++) begin : g_fs
			assign next_audioFsIn[i] = pick(vecFs, field[F_FS+i]);
		end
		// R10
		for (i = 0; i < AUDIO_PINS; i++) begin : g_apin
			assign next_audioPinOut[i] = pick(vecAPin, field[F_APIN+i]);
			assign next_audioPinOe[i] = pick(vecAEn, field[F_AEN+i]);
		end
		// R16
		for (i = 0; i < AUDIO_IRQ_N; i++) begin : g_airq
			assign next_audioIrqRouteIn[i] =
				pick(vecAMsc, field[F_AIRQ+i]);
		end
		for (i = 0; i < AUDIO_MISC_N; i++) begin : g_amisc
			assign audioMiscRaw[i] = pick(vecAMsc, field[F_AMISC+i]);
		end
		// R07 R17
		for (i = 0; i < PERIPH_IN_N; i++) begin : g_pin
			assign next_periphMiscIn[i] = pick(vecPMsc, field[F_PIN_IN+i]);
		end
		for (i = 0; i < PERIPH_IRQ_N; i++) begin : g_pirq
			assign next_periphIrqRouteIn[i] =
				pick(vecPMsc, field[F_PIRQ+i]);
		end
		for (i = 0; i < PERIPH_MISC_N; i++) begin : g_pmisc
			assign periphMiscBuf[i] = pick(vecPMsc, field[F_PMISC+i]);
		end
		// R11
		for (i = 0; i < PERIPH_PINS; i++) begin : g_ppin
			assign next_periphPinOut[i] = pick(vecPPin, field[F_PPIN+i]);
			assign next_periphPinOe[i] = pick(vecPEn, field[F_PEN+i]);
		end
	endgenerate

	// R14
	wire [AUDIO_MISC_N-1:0] miscInvMask =
		AUDIO_MISC_N'({invert[INV_MISC5], invert[INV_MISC4]}) << MISC4_IDX;
	assign audioMiscBuf = audioMiscRaw ^ miscInvMask;

	// ------------------------------------------------------------------
	// Routed outputs
	// ------------------------------------------------------------------
	// Registering every route trades one cycle of latency for
	// glitch-free switching when a field is rewritten
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			audioClkIn       <= '0; // R20
			audioDataIn      <= '0;
			audioFsIn        <= '0;
			audioIrqRouteIn  <= '0;
			audioPinOut      <= '0;
			audioPinOe       <= '0;
			periphMiscIn     <= '0;
			periphIrqRouteIn <= '0;
			periphPinOut     <= '0;
			periphPinOe      <= '0;
		end else begin
			audioClkIn       <= next_audioClkIn; // R22 R04
			audioDataIn      <= next_audioDataIn;
			audioFsIn        <= next_audioFsIn;
			audioIrqRouteIn  <= next_audioIrqRouteIn;
			audioPinOut      <= next_audioPinOut; // R09
			audioPinOe       <= next_audioPinOe; // R09
			periphMiscIn     <= next_periphMiscIn;
			periphIrqRouteIn <= next_periphIrqRouteIn;
			periphPinOut     <= next_periphPinOut; // R09
			periphPinOe      <= next_periphPinOe; // R09
		end
	end

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire        access    = psel & penable & ~pready;
	wire [9:0]  wordIdx   = paddr[11:2];
	wire        cfgHit    = wordIdx < 10'(WORDS);
	wire        invHit    = paddr == INVERT_OFS;
	wire        aStatHit  = paddr == AUDIO_STAT_OFS;
	wire        pStatHit  = paddr == PERIPH_STAT_OFS;
	wire        mapped    = cfgHit | invHit | aStatHit | pStatHit;
	wire        alignedOk = paddr[1:0] == 2'h0;
	wire        badAccess = ~mapped | ~alignedOk;
	wire [4:0]  cfgSel    = cfgHit ? wordIdx[4:0] : 5'h0;
	wire [31:0] oldWord   = {2'h0, cfgWord[cfgSel]};
	wire [31:0] byteMask  = {{8{pstrb[3]}}, {8{pstrb[2]}},
		{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0] mergedWord = (pwdata & byteMask) | (oldWord & ~byteMask);
	wire        cfgWrite  = access & pwrite & cfgHit & alignedOk;
	wire        invWrite  = access & pwrite & invHit & pstrb[0];

	wire [31:0] readWord =
		(cfgHit & alignedOk) ? oldWord :
		invHit   ? 32'(invert) :
		aStatHit ? 32'(audioPinIn) : // R21
		pStatHit ? 32'(periphPinIn) : // R21
		32'h0000_0000;

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int w = 0; w < WORDS; w++) begin
				cfgWord[w] <= WORD_RESET; // R20
			end
			invert <= INVERT_RESET;
		end else begin
			if (cfgWrite) begin
				cfgWord[cfgSel] <= mergedWord[WORD_W-1:0]; // R22
			end
			if (invWrite) begin
				invert <= pwdata[INV_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus answer: one wait state, all outputs registered
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access;
			pslverr <= access & badAccess;
			if (access && !pwrite) begin
				prdata <= readWord;
			end
		end
	end

endmodule : signal_routing_matrix

`default_nettype wire

//--- sim/pin_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Board pads
// ----------------
module pin_pad_model (
	input  wire logic [routing_pkg::AUDIO_PINS-1:0]  aOe,
	input  wire logic [routing_pkg::AUDIO_PINS-1:0]  aOut,
	input  wire logic [routing_pkg::AUDIO_PINS-1:0]  aBoard,
	output logic      [routing_pkg::AUDIO_PINS-1:0]  aLevel,
	input  wire logic [routing_pkg::PERIPH_PINS-1:0] pOe,
	input  wire logic [routing_pkg::PERIPH_PINS-1:0] pOut,
	input  wire logic [routing_pkg::PERIPH_PINS-1:0] pBoard,
	output logic      [routing_pkg::PERIPH_PINS-1:0] pLevel
);
	// One driver per pad: the buffer or the board, never both
	assign aLevel = (aOe & aOut) | (~aOe & aBoard);
	assign pLevel = (pOe & pOut) | (~pOe & pBoard);
endmodule : pin_pad_model
`default_nettype wire

//--- sim/routing_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Bus and route checks
// ----------------
module routing_checker (
	input wire logic                                   clk,
	input wire logic                                   resetn,
	input wire logic                                   psel,
	input wire logic                                   penable,
	input wire logic                                   pwrite,
	input wire logic [routing_pkg::ADDR_W-1:0]         paddr,
	input wire logic                                   pready,
	input wire logic                                   pslverr,
	input wire logic [routing_pkg::AUDIO_PINS-1:0]     audioPinOe,
	input wire logic [routing_pkg::PERIPH_PINS-1:0]    periphPinOe,
	input wire logic [routing_pkg::PERIPH_PIN_SRC-1:0] periphPinSrc,
	input wire logic [routing_pkg::PERIPH_PINS-1:0]    periphPinIn,
	input wire logic [routing_pkg::PERIPH_PINS-1:0]    periphPinOut
);
	import routing_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wire logic acc = psel && penable && !pready;

	wait_state_a: assert property (acc |=> pready)
		else $error("ready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	misalign_err_a: assert property ((acc && paddr[1:0] != 2'h0)
		|=> pready && pslverr) else $error("misaligned access accepted");
	unmapped_err_a: assert property ((acc && paddr > 12'h088)
		|=> pready && pslverr) else $error("unmapped access accepted");
	status_write_a: assert property ((acc && pwrite
		&& paddr == PERIPH_STAT_OFS) |=> !pslverr) else $error("status error");
	reset_quiet_a: assert property ($rose(resetn)
		|-> audioPinOe == '0 && periphPinOe == '0) else $error("drive at reset");
	route_hold_a: assert property ((!pready && $stable(periphPinSrc)
		&& $stable(periphPinIn)) |=> $stable(periphPinOut))
		else $error("route moved without cause");
endmodule : routing_checker

bind signal_routing_matrix routing_checker routing_checker_inst (
	.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.audioPinOe, .periphPinOe, .periphPinSrc, .periphPinIn, .periphPinOut
);
`default_nettype wire

//--- sim/tb_signal_routing_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module tb_signal_routing_matrix;
	import routing_pkg::*;
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  pstrb;
	logic [15:0] audioDataSrc, audioFsSrc, audioEnSrc, periphMiscSrc;
	logic [23:0] audioPinSrc, periphPinSrc, periphEnSrc;
	logic [7:0]  audioMiscSrc, audioClkIn, audioDataIn, audioFsIn, periphMiscIn;
	logic [8:0]  audioClkSrc, periphIrqRouteIn;
	logic [9:0]  audioIrqRouteIn;
	logic [19:0] audioPinIn, audioPinOut, audioPinOe, aBoard;
	logic [13:0] periphPinIn, periphPinOut, periphPinOe, pBoard;
	int          nErrors, checkCount, cycles;

	signal_routing_matrix signal_routing_matrix_inst (
		.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .audioClkSrc, .audioClkIn, .audioDataSrc,
		.audioDataIn, .audioFsSrc, .audioFsIn, .audioPinSrc, .audioMiscSrc,
		.audioIrqRouteIn, .audioEnSrc, .audioPinIn, .audioPinOut, .audioPinOe,
		.periphMiscSrc, .periphMiscIn, .periphIrqRouteIn, .periphPinSrc,
		.periphEnSrc, .periphPinIn, .periphPinOut, .periphPinOe
	);
	pin_pad_model pin_pad_model_inst (
		.aOe(audioPinOe), .aOut(audioPinOut), .aBoard, .aLevel(audioPinIn),
		.pOe(periphPinOe), .pOut(periphPinOut), .pBoard, .pLevel(periphPinIn)
	);

	// ----------------
	// Helpers
	// ----------------
	task complete_run;
		$display("comparisons %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
		// A slave that never answers ends the run here
		if (n >= 20) begin
			nErrors++;
			complete_run;
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task set_field(input int f, input logic [5:0] c);
		logic [11:0] a;
		a = 12'(f / FIELDS_PER_WORD * 4);
		apb(1'b0, a, 32'h0, q, e);
		q[f % FIELDS_PER_WORD * FIELD_W +: FIELD_W] = c;
		apb(1'b1, a, q, q, e);
		settle;
	endtask : set_field

	// ----------------
	// Scenarios
	// ----------------
	task t_reset_refuse;
		chk(32'({audioClkIn, audioPinOe}), 32'h0);
		chk(32'({periphPinOe, periphMiscIn, audioIrqRouteIn}), 32'h0);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk(q, {2'h0, WORD_RESET});
		apb(1'b0, 12'h100, 32'h0, q, e);
		chk(32'(e), 32'h1);
		apb(1'b1, 12'h006, 32'hFFFFFFFF, q, e);
		chk(32'(e), 32'h1);
		apb(1'b1, PERIPH_STAT_OFS, 32'h0, q, e);
		chk(32'(e), 32'h0);
		pstrb <= 4'hE;
		apb(1'b1, INVERT_OFS, 32'h0000_000F, q, e);
		pstrb <= 4'hF;
		apb(1'b0, INVERT_OFS, 32'h0, q, e);
		chk(q, 32'h0);
	endtask : t_reset_refuse

	task t_clock;
		for (int f = 0; f < AUDIO_CLK_N; f++)
			set_field(F_CLK + f, 6'h15);
		@(posedge clk);
		audioClkSrc <= 9'h002;
		settle;
		chk(32'(audioClkIn), 32'hFF);
		for (int k = 0; k < AUDIO_CLK_SRC; k++) begin
			set_field(F_CLK, 6'(k + 8'h14));
			@(posedge clk);
			audioClkSrc <= ~(9'h001 << k);
			settle;
			chk(32'(audioClkIn[0]), 32'h0);
			@(posedge clk);
			audioClkSrc <= 9'h001 << k;
			settle;
			chk(32'(audioClkIn[0]), 32'h1);
		end
		chk(32'(audioDataIn), 32'h0);
		set_field(F_CLK, CODE_HIGH);
		chk(32'(audioClkIn[0]), 32'h1);
		set_field(F_CLK, 6'h30);
		chk(32'(audioClkIn[0]), 32'h0);
		set_field(F_CLK, 6'h05);
		chk(32'(audioClkIn[0]), 32'h1);
		set_field(F_DATA + 7, 6'h23);
		set_field(F_FS + 3, 6'h05);
		chk(32'({audioDataIn, audioFsIn}), 32'h8008);
	endtask : t_clock

	task t_invert;
		set_field(F_CLK, 6'h12);
		chk(32'(audioClkIn[0]), 32'h1);
		apb(1'b1, INVERT_OFS, 32'h1, q, e);
		settle;
		chk(32'(audioClkIn[0]), 32'h0);
		set_field(F_APIN + PIN19_IDX, 6'h12);
		chk(32'(audioClkIn[0]), 32'h1);
		set_field(F_AMISC + MISC4_IDX, CODE_HIGH);
		set_field(F_AEN + 2, 6'h28);
		chk(32'(audioPinOe[2]), 32'h1);
		apb(1'b1, INVERT_OFS, 32'h4, q, e);
		settle;
		chk(32'(audioPinOe[2]), 32'h0);
	endtask : t_invert

	task t_irq;
		for (int j = 0; j < AUDIO_IRQ_N; j++)
			set_field(F_AIRQ + j, CODE_HIGH);
		for (int j = 0; j < PERIPH_IRQ_N; j++)
			set_field(F_PIRQ + j, 6'(j + 8'h0E));
		for (int j = 0; j < PERIPH_IN_N; j++)
			set_field(F_PIN_IN + j, 6'(j + 8'h16));
		chk(32'(audioIrqRouteIn), 32'h3FF);
		chk(32'(periphIrqRouteIn), 32'(periphMiscSrc[8:0]));
		chk(32'(periphMiscIn), 32'(periphMiscSrc[15:8]));
		set_field(F_PMISC + 8, CODE_HIGH);
		set_field(F_PEN, 6'h2E);
		chk(32'(periphPinOe[0]), 32'h1);
	endtask : t_irq

	task t_pins;
		set_field(F_APIN, CODE_HIGH);
		set_field(F_AEN, 6'h01);
		chk(32'({audioPinOe[0], audioPinIn[0]}), 32'h0);
		@(posedge clk);
		aBoard[1] <= 1'b1;
		settle;
		chk(32'({audioPinOe[0], audioPinIn[0]}), 32'h3);
		for (int p = 0; p < AUDIO_PINS; p++) begin
			set_field(F_APIN + p, CODE_HIGH);
			set_field(F_AEN + p, CODE_HIGH);
		end
		for (int p = 0; p < PERIPH_PINS; p++) begin
			set_field(F_PPIN + p, 6'(p + 8'h0E));
			set_field(F_PEN + p, CODE_HIGH);
		end
		apb(1'b0, AUDIO_STAT_OFS, 32'h0, q, e);
		chk(q, 32'h000FFFFF);
		apb(1'b0, PERIPH_STAT_OFS, 32'h0, q, e);
		chk(q, 32'(periphPinSrc[13:0]));
		chk(32'(periphPinOe), 32'h3FFF);
	endtask : t_pins

	// ----------------
	// Run
	// ----------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			nErrors++;
			complete_run;
		end
	end

	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		{audioClkSrc, audioFsSrc, audioPinSrc, audioEnSrc} = '0;
		{audioMiscSrc, periphEnSrc, pBoard} = '0;
		audioDataSrc = 16'hFFFF;
		periphMiscSrc = 16'h5A96;
		periphPinSrc = 24'hA5C3E9;
		aBoard = 20'h40020;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_reset_refuse;
		t_clock;
		t_invert;
		t_irq;
		t_pins;
		complete_run;
	end
endmodule : tb_signal_routing_matrix
`default_nettype wire
